// ---- rtl/serial_tx_pkg.sv ----
// serial transmitter package: register map, field positions, reset values, timing
// assumes a 32-bit AXI4-Lite slave where each 8-bit register takes one aligned word
package serial_tx_pkg;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_FLAGS1 = 10'h00C;
   localparam logic [9:0] IDX_RXCTL = 10'h018;
   localparam logic [9:0] IDX_TXHOLD = 10'h019;
   localparam logic [9:0] IDX_ENABLES1 = 10'h08C;
   localparam logic [9:0] IDX_TXCTL = 10'h098;
   localparam logic [9:0] IDX_DIVIDER = 10'h099;
   localparam int ADDR_W = 12;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_PSP = 7;
   localparam int BIT_TXFLAG = 4;
   localparam int BIT_PORT_EN = 7;
   localparam int BIT_CSRC = 7;
   localparam int BIT_NINE_SEL = 6;
   localparam int BIT_TX_EN = 5;
   localparam int BIT_SYNC = 4;
   localparam int BIT_FAST = 2;
   localparam int BIT_SHIFT_EMPTY = 1;
   localparam int BIT_NINTH = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_TXCTL = 8'h02;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // bit timing and buffering
   // ----------------------------------------------------------------
   localparam int PRESCALE_LOW_SHIFT = 6;
   localparam int PRESCALE_HIGH_SHIFT = 4;
   localparam int BAUD_W = 15;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 9;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register selector decoded from an address
   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_FLAGS1 = 3'h1,
      SEL_RXCTL = 3'h2,
      SEL_TXHOLD = 3'h3,
      SEL_ENABLES1 = 3'h4,
      SEL_TXCTL = 3'h5,
      SEL_DIVIDER = 3'h6
   } regSel_t;

   // transmitter phases, one-hot
   typedef enum logic [4:0] {
      PH_IDLE = 5'b00001,
      PH_START = 5'b00010,
      PH_DATA = 5'b00100,
      PH_NINTH = 5'b01000,
      PH_STOP = 5'b10000
   } txPhase_t;

endpackage

// ---- rtl/serial_tx.sv ----
// asynchronous serial transmitter with AXI4-Lite register slave and a word FIFO
// assumes one clock core_clk at 25 MHz and an AXI4-Lite master on the same clock
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module serial_tx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic [PW:0] count;
   } fifoState_t;

   fifoState_t st_ff, nxt_st;

   assign inReady = (st_ff.count != (PW+1)'(DEPTH));
   assign outValid = (st_ff.count != '0);
   assign outData = st_ff.mem[st_ff.rdPtr];

   always_comb begin
      logic push;
      logic pop;
      push = inValid & inReady;
      pop = outValid & outReady;
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wrPtr] = inData;
         nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
      end
      if (pop) begin
         nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
      end
      nxt_st.count = st_ff.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // serial_tx_fifo

module serial_tx (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // axi4-lite write address and data
   input wire logic [serial_tx_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [serial_tx_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // serial line and request
   output logic txLine,
   output logic txIrq
);
   import serial_tx_pkg::*;

   typedef struct packed {
      logic awFull;
      logic wFull;
      logic [ADDR_W-1:0] awAddr;
      logic [7:0] wByte;
      logic wLane0;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [7:0] rByte;
      logic [1:0] rResp;
      logic pspFlag;
      logic parallel_slave_port_enable;
      logic transmit_interrupt_enable;
      logic portEn;
      logic csrc;
      logic nineSel;
      logic transmitter_enable;
      logic sync;
      logic fastRate;
      logic ninthBit;
      logic [7:0] divider;
      txPhase_t ph;
      logic [BAUD_W-1:0] baudCnt;
      logic [3:0] bitCnt;
      logic [8:0] shift;
      logic frame9;
      logic txd;
      logic irq;
   } txState_t;

   txState_t st_ff, nxt_st;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic regSel_t decodeReg(input logic [ADDR_W-1:0] a);
      regSel_t s;
      s = SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[ADDR_W-1:2])
            IDX_FLAGS1: s = SEL_FLAGS1;
            IDX_RXCTL: s = SEL_RXCTL;
            IDX_TXHOLD: s = SEL_TXHOLD;
            IDX_ENABLES1: s = SEL_ENABLES1;
            IDX_TXCTL: s = SEL_TXCTL;
            IDX_DIVIDER: s = SEL_DIVIDER;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // ----------------------------------------------------------------
   // combinational terms
   // ----------------------------------------------------------------
   logic portOn;
   logic txFlag;
   logic [BAUD_W-1:0] baudLimit;
   logic bitTick;
   logic fifoInValid;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [FIFO_WIDTH-1:0] fifoOutData;
   regSel_t wSel;
   logic commit;

   assign portOn = st_ff.portEn & ~st_ff.sync;
   // flag means the holding buffer can take a byte; it rises as soon as the enable is set
   assign txFlag = st_ff.transmitter_enable & fifoInReady;
   // bit period is (divider+1) times 64, or times 16 with high-speed select
   assign baudLimit = ((BAUD_W'(st_ff.divider) + 1'b1) << (st_ff.fastRate ? PRESCALE_HIGH_SHIFT
                      : PRESCALE_LOW_SHIFT)) - 1'b1;
   assign bitTick = (st_ff.baudCnt == baudLimit);
   assign wSel = decodeReg(st_ff.awAddr);
   // a holding write waits for FIFO room, so a full buffer stalls the response
   assign commit = st_ff.awFull & st_ff.wFull & ~st_ff.bValid &
                   ((wSel != SEL_TXHOLD) | ~st_ff.wLane0 | fifoInReady);
   assign fifoInValid = st_ff.awFull & st_ff.wFull & ~st_ff.bValid &
                        (wSel == SEL_TXHOLD) & st_ff.wLane0;
   assign fifoOutReady = portOn & st_ff.transmitter_enable & (st_ff.ph == PH_IDLE);

   serial_tx_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) holdFifo (
      .clk(core_clk),
      .rstn(rstn),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData({st_ff.ninthBit, st_ff.wByte}),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      regSel_t rSel;
      nxt_st = st_ff;
      rSel = decodeReg(araddr);
      // write channels are taken independently
      if (awvalid & st_ff.awReady) begin
         nxt_st.awFull = 1'b1;
         nxt_st.awAddr = awaddr;
      end
      if (wvalid & st_ff.wReady) begin
         nxt_st.wFull = 1'b1;
         nxt_st.wByte = wdata[7:0];
         nxt_st.wLane0 = wstrb[0];
      end
      if (st_ff.bValid & bready) begin
         nxt_st.bValid = 1'b0;
      end
      if (commit) begin
         nxt_st.awFull = 1'b0;
         nxt_st.wFull = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (st_ff.wLane0) begin
            case (wSel)
               SEL_FLAGS1: nxt_st.pspFlag = st_ff.wByte[BIT_PSP];
               SEL_RXCTL: nxt_st.portEn = st_ff.wByte[BIT_PORT_EN];
               SEL_ENABLES1: begin
                  nxt_st.parallel_slave_port_enable = st_ff.wByte[BIT_PSP];
                  nxt_st.transmit_interrupt_enable = st_ff.wByte[BIT_TXFLAG];
               end
               SEL_TXCTL: begin
                  nxt_st.csrc = st_ff.wByte[BIT_CSRC];
                  nxt_st.nineSel = st_ff.wByte[BIT_NINE_SEL];
                  nxt_st.transmitter_enable = st_ff.wByte[BIT_TX_EN];
                  nxt_st.sync = st_ff.wByte[BIT_SYNC];
                  nxt_st.fastRate = st_ff.wByte[BIT_FAST];
                  nxt_st.ninthBit = st_ff.wByte[BIT_NINTH];
               end
               SEL_DIVIDER: nxt_st.divider = st_ff.wByte;
               default: nxt_st.divider = st_ff.divider;
            endcase
         end
      end
      nxt_st.awReady = ~nxt_st.awFull & ~nxt_st.bValid;
      nxt_st.wReady = ~nxt_st.wFull & ~nxt_st.bValid;

      // read channel; unimplemented positions stay zero
      if (st_ff.rValid & rready) begin
         nxt_st.rValid = 1'b0;
         nxt_st.arReady = 1'b1;
      end
      if (arvalid & st_ff.arReady) begin
         nxt_st.arReady = 1'b0;
         nxt_st.rValid = 1'b1;
         nxt_st.rResp = (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         nxt_st.rByte = 8'h00;
         case (rSel)
            SEL_FLAGS1: begin
               nxt_st.rByte[BIT_PSP] = st_ff.pspFlag;
               nxt_st.rByte[BIT_TXFLAG] = txFlag;
            end
            SEL_RXCTL: nxt_st.rByte[BIT_PORT_EN] = st_ff.portEn;
            SEL_ENABLES1: begin
               nxt_st.rByte[BIT_PSP] = st_ff.parallel_slave_port_enable;
               nxt_st.rByte[BIT_TXFLAG] = st_ff.transmit_interrupt_enable;
            end
            SEL_TXCTL: nxt_st.rByte = {st_ff.csrc, st_ff.nineSel, st_ff.transmitter_enable, st_ff.sync, 1'b0,
                                       st_ff.fastRate, st_ff.ph == PH_IDLE, st_ff.ninthBit};
            SEL_DIVIDER: nxt_st.rByte = st_ff.divider;
            default: nxt_st.rByte = 8'h00;
         endcase
      end

      // bit timer restarts at every frame so the start bit is full length
      if (st_ff.ph == PH_IDLE || bitTick) begin
         nxt_st.baudCnt = '0;
      end else begin
         nxt_st.baudCnt = st_ff.baudCnt + 1'b1;
      end

      // transmitter; dropping the enable aborts the frame and idles the line
      case (st_ff.ph)
         PH_IDLE: begin
            if (fifoOutValid & fifoOutReady) begin
               nxt_st.ph = PH_START;
               nxt_st.shift = fifoOutData;
               nxt_st.frame9 = st_ff.nineSel;
               nxt_st.bitCnt = 4'h0;
            end
         end
         PH_START: begin
            if (bitTick) begin
               nxt_st.ph = PH_DATA;
            end
         end
         PH_DATA: begin
            if (bitTick) begin
               nxt_st.shift = {1'b0, st_ff.shift[8:1]};
               nxt_st.bitCnt = st_ff.bitCnt + 1'b1;
               if (st_ff.bitCnt == LAST_DATA_BIT) begin
                  nxt_st.ph = st_ff.frame9 ? PH_NINTH : PH_STOP;
               end
            end
         end
         PH_NINTH: begin
            if (bitTick) begin
               nxt_st.ph = PH_STOP;
            end
         end
         PH_STOP: begin
            if (bitTick) begin
               nxt_st.ph = PH_IDLE;
            end
         end
         default: nxt_st.ph = PH_IDLE;
      endcase
      if (!(portOn & st_ff.transmitter_enable)) begin
         nxt_st.ph = PH_IDLE;
      end

      // line level follows the phase being entered
      case (nxt_st.ph)
         PH_START: nxt_st.txd = 1'b0;
         PH_DATA, PH_NINTH: nxt_st.txd = nxt_st.shift[0];
         default: nxt_st.txd = 1'b1;
      endcase
      nxt_st.irq = st_ff.transmit_interrupt_enable & txFlag;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
         st_ff.awReady <= 1'b1;
         st_ff.wReady <= 1'b1;
         st_ff.arReady <= 1'b1;
         st_ff.ph <= PH_IDLE;
         st_ff.txd <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign awready = st_ff.awReady;
   assign wready = st_ff.wReady;
   assign bvalid = st_ff.bValid;
   assign bresp = st_ff.bResp;
   assign arready = st_ff.arReady;
   assign rvalid = st_ff.rValid;
   assign rresp = st_ff.rResp;
   assign rdata = {24'h000000, st_ff.rByte};
   assign txLine = st_ff.txd;
   assign txIrq = st_ff.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_port_off_idle: assert property (!portOn |=> st_ff.ph == PH_IDLE && txLine)
      else $error("transmitter active while port disabled");
   a_irq_gate: assert property (st_ff.transmit_interrupt_enable && st_ff.transmitter_enable && fifoInReady |=> txIrq)
      else $error("interrupt request missing");
   a_irq_masked: assert property (!st_ff.transmit_interrupt_enable |=> !txIrq)
      else $error("interrupt request while masked");
   a_ninth_bit: assert property (st_ff.ph == PH_DATA && bitTick && st_ff.bitCnt == LAST_DATA_BIT
      && st_ff.frame9 && portOn && st_ff.transmitter_enable |=> st_ff.ph == PH_NINTH)
      else $error("ninth bit skipped");
   a_enable_flag: assert property ($rose(st_ff.transmitter_enable) && fifoInReady |-> txFlag)
      else $error("flag not raised by enable");
   a_write_starts: assert property (fifoInValid && fifoInReady && !fifoOutValid && portOn
      && st_ff.transmitter_enable && st_ff.ph == PH_IDLE |-> ##2 st_ff.ph == PH_START)
      else $error("holding write did not start frame");
   a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("unimplemented bits nonzero");
   a_baud_wrap: assert property (bitTick && st_ff.ph != PH_IDLE |=> st_ff.baudCnt == '0
      && st_ff.ph != PH_START)
      else $error("bit timer did not wrap");
   a_start_low: assert property (st_ff.ph == PH_START |-> !txLine)
      else $error("start bit not low");
   a_stop_high: assert property (st_ff.ph == PH_STOP || st_ff.ph == PH_IDLE |-> txLine)
      else $error("line not high in stop or idle");

   c_nine_bit_frame: cover property (st_ff.ph == PH_NINTH ##[1:1000] st_ff.ph == PH_STOP);
   c_back_to_back: cover property (st_ff.ph == PH_STOP ##1 st_ff.ph == PH_START);
   c_fifo_full: cover property (!fifoInReady && fifoInValid);
   c_status_read: cover property (rvalid && rready);
endmodule // serial_tx

`default_nettype wire

// ---- verification/serial_rx_model.sv ----
// remote asynchronous receiver model for the serial transmitter bench
// assumes the line idles high and the bench gives the bit length in clocks
`timescale 1ns/10ps
`default_nettype none
module serial_rx_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // line and frame setup
   input wire logic txLine,
   input wire logic [15:0] bitLen,
   input wire logic nine,
   // received frames: bit 9 flags a bad stop bit
   output logic rxStrb,
   output logic [9:0] rxWord
);
   logic [8:0] sh;
   logic useNine;
   initial begin
      rxStrb = 1'h0;
      rxWord = 10'h000;
   end
   // ----------------------------------------------------------------
   // mid-bit sampling
   // ----------------------------------------------------------------
   // a wrong bit period shifts every sample, so the word comes out garbled
   always begin
      @(negedge txLine);
      if (rstn) begin
         useNine = nine;
         sh = 9'h000;
         repeat (bitLen / 2) @(posedge core_clk);
         if (txLine === 1'h0) begin
            for (int i = 0; i < (useNine ? 9 : 8); i++) begin
               repeat (bitLen) @(posedge core_clk);
               sh[i] = txLine;
            end
            repeat (bitLen) @(posedge core_clk);
            rxWord <= {txLine !== 1'h1, sh};
            rxStrb <= 1'h1;
            @(posedge core_clk);
            rxStrb <= 1'h0;
         end
      end
   end
endmodule // serial_rx_model
`default_nettype wire

// ---- verification/tb_serial_tx.sv ----
// self-checking bench: register access over AXI4-Lite, frames judged by a receiver model
// assumes the design answers every bus request and that holding writes always enter the FIFO
`timescale 1ns/10ps
`default_nettype none
module tb_serial_tx;
   import serial_tx_pkg::*;
   logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready, nine, rxStrb;
   logic awready, wready, bvalid, arready, rvalid, txLine, txIrq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rw;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] bitLen;
   logic [9:0] rxWord;
   logic [9:0] rxq[$];
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   localparam logic [ADDR_W-1:0] A_FL = {IDX_FLAGS1, 2'h0};
   localparam logic [ADDR_W-1:0] A_RX = {IDX_RXCTL, 2'h0};
   localparam logic [ADDR_W-1:0] A_TH = {IDX_TXHOLD, 2'h0};
   localparam logic [ADDR_W-1:0] A_EN = {IDX_ENABLES1, 2'h0};
   localparam logic [ADDR_W-1:0] A_TC = {IDX_TXCTL, 2'h0};
   localparam logic [ADDR_W-1:0] A_DV = {IDX_DIVIDER, 2'h0};

   serial_tx dut (.core_clk(core_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .txLine(txLine), .txIrq(txIrq));
   serial_rx_model rxm (.core_clk(core_clk), .rstn(rstn), .txLine(txLine), .bitLen(bitLen), .nine(nine),
      .rxStrb(rxStrb), .rxWord(rxWord));

   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (rxStrb) rxq.push_back(rxWord);
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // bready is lowered and one edge passes so a following call never drives it twice at once
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      resp = bresp;
      bready <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rw = rdata;
      resp = rresp;
      rready <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(rw, exp, what);
   endtask
   task automatic rxchk(input logic [9:0] exp);
      for (int t = 0; t < 3000 && rxq.size() == 0; t++) @(posedge core_clk);
      chk({22'h000000, (rxq.size() > 0) ? rxq.pop_front() : 10'h3FF}, {22'h000000, exp}, "frame");
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         $display("[ERR] %0t run did not finish", $time);
         results;
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [ADDR_W-1:0] al[6];
      logic [7:0] rvals[6];
      al = '{A_FL, A_RX, A_TH, A_EN, A_TC, A_DV};
      rvals = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
      rstn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready, nine} = 6'h00;
      awaddr = '0;
      araddr = '0;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      bitLen = 16'h0010;
      repeat (3) @(posedge core_clk);
      rstn <= 1'h1;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++) rdchk(al[i], {24'h000000, rvals[i]}, "reset value");
      rd(12'h004);
      chk(resp, RESP_SLVERR, "unmapped read");
      wr(12'h066, 8'h00);
      chk(resp, RESP_SLVERR, "misaligned write");
      wr(A_FL, 8'hFF);
      rdchk(A_FL, 32'h00000080, "flag bits");
      wr(A_FL, 8'h00);
      chk(resp, RESP_OKAY, "mapped write");
      rd(A_FL);
      chk(resp, RESP_OKAY, "mapped read");
      $display("test registers done");
      wr(A_DV, 8'h00);
      wr(A_TC, 8'h04);
      wr(A_RX, 8'h80);
      wr(A_EN, 8'h10);
      chk(txIrq, 32'h0, "request without transmitter");
      wr(A_TC, 8'h24);
      rdchk(A_FL, 32'h00000010, "buffer empty flag");
      rdchk(A_TC, 32'h00000026, "idle status");
      chk(txIrq, 32'h1, "request enabled");
      wr(A_TH, 8'hA5);
      rxchk(10'h0A5);
      wr(A_EN, 8'h00);
      chk(txIrq, 32'h0, "request masked");
      $display("test single frame done");
      nine <= 1'h1;
      wr(A_TC, 8'h65);
      wr(A_TH, 8'h3C);
      rxchk(10'h13C);
      wr(A_TC, 8'h64);
      wr(A_TH, 8'hC3);
      rxchk(10'h0C3);
      nine <= 1'h0;
      $display("test nine bit done");
      // synchronous select parks the transmitter so the FIFO can be filled to the brim
      wr(A_TC, 8'h34);
      for (int i = 0; i < FIFO_DEPTH; i++) wr(A_TH, 8'h40 + i[7:0]);
      rdchk(A_FL, 32'h00000000, "full buffer");
      chk(rxq.size(), 32'h0, "halted line");
      chk(txLine, 32'h1, "idle level");
      wr(A_TC, 8'h24);
      for (int i = 0; i < FIFO_DEPTH; i++) rxchk({2'h0, 8'h40 + i[7:0]});
      rdchk(A_FL, 32'h00000010, "drained buffer");
      $display("test fifo done");
      bitLen <= 16'h0080;
      wr(A_DV, 8'h01);
      wr(A_TC, 8'h20);
      wr(A_TH, 8'h5A);
      rxchk(10'h05A);
      $display("test low speed done");
      results;
   end
endmodule // tb_serial_tx
`default_nettype wire
